// ==== cbrdg_pkg.sv ====
`default_nettype none
package cbrdg_pkg;
  localparam int          AD_W         = 32;
  localparam int          BE_W         = 4;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          CLOCK_MHZ    = 125;
  // Ticks of i_clock per half cycle of the bus clock
  localparam int          PHASE_TICKS  = 3;
  localparam int          CYCLE_TICKS  = 2 * PHASE_TICKS;
  localparam int          PH_W         = 3;
  localparam logic [2:0]  PH_RISE      = 3'h0;
  localparam logic [2:0]  PH_ADDR_LAST = 3'h2;
  localparam logic [2:0]  PH_FALL      = 3'h3;
  localparam logic [2:0]  PH_TRISTATE  = 3'h4;
  localparam logic [2:0]  PH_LAST      = 3'h5;
  localparam logic [2:0]  BLOCK_WORDS  = 3'h4;
  localparam logic [2:0]  SINGLE_WORDS = 3'h1;
  localparam logic [2:0]  NO_WORDS     = 3'h0;
  localparam logic [1:0]  BLOCK_START  = 2'h0;
  localparam logic [3:0]  BE_FULL      = 4'hF;
  localparam int          DIAG_HI_BIT  = 3;
  localparam int          DIAG_LO_BIT  = 2;
  localparam logic [31:0] AD_IDLE      = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_TURN,
    ST_DATA,
    ST_DMA_REL,
    ST_DMA_GNT,
    ST_DMA_END
  } cbrdg_state_t;
endpackage
`default_nettype wire

// ==== cbrdg_bus_if.sv ====
`default_nettype none
interface cbrdg_bus_if;
  logic        system_clock_output;
  logic [31:0] cpu_ad_o;
  logic        cpu_ad_oe;
  logic [31:0] mem_ad_o;
  logic        mem_ad_oe;
  logic [31:0] ad_bus;
  logic        ctl_oe;
  logic        ale;
  logic        rd_n;
  logic        burst_n;
  logic [1:0]  low_addr;
  logic        diag1;
  logic        diag0;
  logic        memory_drive_permit_n;
  logic        read_capture_enable_n;
  logic        ack_n;
  logic        dma_bus_request_n;
  logic        dma_bus_grant_n;
  logic        ale_bus;
  logic        rd_bus_n;
  logic        burst_bus_n;
  logic        permit_bus_n;

  // Released control pins settle to their idle levels
  assign ale_bus      = ctl_oe & ale;
  assign rd_bus_n     = rd_n | ~ctl_oe;
  assign burst_bus_n  = burst_n | ~ctl_oe;
  assign permit_bus_n = memory_drive_permit_n | ~ctl_oe;
  assign ad_bus       = cpu_ad_oe ? cpu_ad_o : (mem_ad_oe ? mem_ad_o : cbrdg_pkg::AD_IDLE);

  modport cpu (
    output system_clock_output, cpu_ad_o, cpu_ad_oe, ctl_oe, ale, rd_n, burst_n,
    output low_addr, diag1, diag0, memory_drive_permit_n, dma_bus_grant_n,
    input  ad_bus, read_capture_enable_n, ack_n, dma_bus_request_n
  );
  modport mem (
    input  system_clock_output, ad_bus, ale_bus, rd_bus_n, burst_bus_n, low_addr,
    input  diag1, diag0, permit_bus_n, dma_bus_grant_n,
    output mem_ad_o, mem_ad_oe, read_capture_enable_n, ack_n, dma_bus_request_n
  );
endinterface
`default_nettype wire

// ==== cbrdg_fifo.sv ====
`default_nettype none
module cbrdg_fifo #(
  parameter int WIDTH = cbrdg_pkg::AD_W,
  parameter int DEPTH = cbrdg_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_q != rd_q;
  assign o_out_data  = mem_q[rd_q[AW-1:0]];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== cbrdg_cpu_end.sv ====
// How it works
// - Address phase diag1 high flags a cache miss
// - After address phase diag1 shows address bit 3
// - Address phase diag0 high means instruction miss
// - After address phase diag0 shows address bit 2
// - Bus request tri-states outputs; negation returns bus
// - Grant asserted only after outputs are released
// - Bus reads only for misses or uncached references
// - Instruction misses block; data misses follow strap
// - Subword reads are single reads with byte enables
// - Read strobe, address and latch strobe at rise
// - Drive permit stays high during address phase
// - Burst flag low for block, high for single
// - Low address 00 for block, word address otherwise
// - Address half cycle; turnaround in second phase
// - Latch strobe off, then tristate, then permit
// - Memory drives only while permit is asserted or it holds the DMA grant
// - Termination inputs watched from second cycle onward
// - Memory returns words no sooner than two cycles
// - Block low address counts up from 00
// - Permit negated when no read is running
// - Capture sampled at rise, data latched at fall
`default_nettype none
module cbrdg_cpu_end (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_dcache_block_strap,
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic [31:0] i_req_addr,
  input  wire logic        i_req_miss,
  input  wire logic        i_req_instr,
  input  wire logic [3:0]  i_req_be,
  output logic [31:0]      o_rdata,
  output logic             o_rdata_valid,
  output logic             o_core_release,
  output logic             o_read_done,
  output logic             o_dma_granted,
  cbrdg_bus_if.cpu         bus
);
  cbrdg_pkg::cbrdg_state_t state_q;
  cbrdg_pkg::cbrdg_state_t state_d;

  logic [2:0]  ph_q;
  logic [2:0]  ph_d;
  logic        strap_taken_q;
  logic        mode_block_q;
  logic [31:0] addr_q;
  logic        miss_q;
  logic        instr_q;
  logic        burst_q;
  logic [3:0]  be_q;
  logic [1:0]  word_q;
  logic [2:0]  words_left_q;
  logic        sampled_q;
  logic        start;
  logic        last_capture;
  logic [31:0] s_addr;
  logic        s_miss;
  logic        s_instr;
  logic        s_burst;
  logic [3:0]  s_be;

  logic        system_clock_output_q;
  logic        ale_q;
  logic        ad_oe_q;
  logic [31:0] ad_o_q;
  logic        ctl_oe_q;
  logic        rd_n_q;
  logic        burst_n_q;
  logic [1:0]  low_addr_q;
  logic        diag1_q;
  logic        diag0_q;
  logic        permit_n_q;
  logic        grant_n_q;

  function automatic logic is_read(input cbrdg_pkg::cbrdg_state_t s);
    is_read = (s == cbrdg_pkg::ST_ADDR) || (s == cbrdg_pkg::ST_TURN) ||
              (s == cbrdg_pkg::ST_DATA);
  endfunction

  function automatic logic is_dma(input cbrdg_pkg::cbrdg_state_t s);
    is_dma = (s == cbrdg_pkg::ST_DMA_REL) || (s == cbrdg_pkg::ST_DMA_GNT) ||
             (s == cbrdg_pkg::ST_DMA_END);
  endfunction

  assign ph_d = (ph_q == cbrdg_pkg::PH_LAST) ? cbrdg_pkg::PH_RISE : ph_q + 3'h1;
  assign last_capture = (state_q == cbrdg_pkg::ST_DATA) && (ph_q == cbrdg_pkg::PH_FALL) &&
                        sampled_q && (words_left_q == cbrdg_pkg::SINGLE_WORDS);
  assign start = (state_q == cbrdg_pkg::ST_IDLE) && (state_d == cbrdg_pkg::ST_ADDR);
  assign o_req_ready = start;

  // Request fields are taken straight from the port on the starting tick
  assign s_addr  = start ? i_req_addr  : addr_q;
  assign s_miss  = start ? i_req_miss  : miss_q;
  assign s_instr = start ? i_req_instr : instr_q;
  assign s_be    = start ? i_req_be    : be_q;
  assign s_burst = start ? (i_req_miss && (i_req_instr || mode_block_q) &&
                            (i_req_be == cbrdg_pkg::BE_FULL)) : burst_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      cbrdg_pkg::ST_IDLE: begin
        if (!bus.dma_bus_request_n) begin
          state_d = cbrdg_pkg::ST_DMA_REL;
        end else if (i_req_valid && strap_taken_q && (ph_q == cbrdg_pkg::PH_LAST)) begin
          state_d = cbrdg_pkg::ST_ADDR;
        end
      end
      cbrdg_pkg::ST_ADDR: begin
        if (ph_q == cbrdg_pkg::PH_ADDR_LAST) begin
          state_d = cbrdg_pkg::ST_TURN;
        end
      end
      cbrdg_pkg::ST_TURN: begin
        if (ph_q == cbrdg_pkg::PH_LAST) begin
          state_d = cbrdg_pkg::ST_DATA;
        end
      end
      cbrdg_pkg::ST_DATA: begin
        if (last_capture) begin
          state_d = cbrdg_pkg::ST_IDLE;
        end
      end
      cbrdg_pkg::ST_DMA_REL: begin
        state_d = cbrdg_pkg::ST_DMA_GNT;
      end
      cbrdg_pkg::ST_DMA_GNT: begin
        if (bus.dma_bus_request_n) begin
          state_d = cbrdg_pkg::ST_DMA_END;
        end
      end
      cbrdg_pkg::ST_DMA_END: begin
        state_d = cbrdg_pkg::ST_IDLE;
      end
      default: begin
        state_d = cbrdg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= cbrdg_pkg::ST_IDLE;
      ph_q    <= cbrdg_pkg::PH_RISE;
    end else begin
      state_q <= state_d;
      ph_q    <= ph_d;
    end
  end

  // Strap is caught on the first edge after reset release, not by the reset itself
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_taken_q <= 1'b0;
      mode_block_q  <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      mode_block_q  <= i_dcache_block_strap;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_q  <= 32'h0000_0000;
      miss_q  <= 1'b0;
      instr_q <= 1'b0;
      burst_q <= 1'b0;
      be_q    <= 4'h0;
    end else if (start) begin
      addr_q  <= i_req_addr;
      miss_q  <= i_req_miss;
      instr_q <= i_req_instr;
      burst_q <= s_burst;
      be_q    <= i_req_be;
    end
  end

  // Bus pins, registered from the next state and phase
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      system_clock_output_q   <= 1'b1;
      ale_q      <= 1'b0;
      ad_oe_q    <= 1'b0;
      ad_o_q     <= 32'h0000_0000;
      ctl_oe_q   <= 1'b1;
      rd_n_q     <= 1'b1;
      burst_n_q  <= 1'b1;
      permit_n_q <= 1'b1;
      grant_n_q  <= 1'b1;
    end else begin
      system_clock_output_q   <= ph_d < cbrdg_pkg::PH_FALL;
      ale_q      <= state_d == cbrdg_pkg::ST_ADDR;
      // Driver stays on one tick past the latch strobe so the latch closes on a stable bus
      ad_oe_q    <= (state_d == cbrdg_pkg::ST_ADDR) ||
                    ((state_d == cbrdg_pkg::ST_TURN) && (ph_d == cbrdg_pkg::PH_FALL));
      ad_o_q     <= {s_addr[31:4], ~s_be};
      ctl_oe_q   <= !is_dma(state_d);
      rd_n_q     <= !is_read(state_d);
      burst_n_q  <= !(is_read(state_d) && s_burst);
      permit_n_q <= !(((state_d == cbrdg_pkg::ST_TURN) && (ph_d == cbrdg_pkg::PH_LAST)) ||
                      (state_d == cbrdg_pkg::ST_DATA));
      grant_n_q  <= state_d != cbrdg_pkg::ST_DMA_GNT;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      low_addr_q <= cbrdg_pkg::BLOCK_START;
      diag1_q    <= 1'b0;
      diag0_q    <= 1'b0;
    end else if (state_d == cbrdg_pkg::ST_ADDR) begin
      low_addr_q <= s_burst ? cbrdg_pkg::BLOCK_START : s_addr[3:2];
      diag1_q    <= s_miss;
      diag0_q    <= s_miss && s_instr;
    end else begin
      low_addr_q <= burst_q ? word_q : addr_q[3:2];
      diag1_q    <= addr_q[cbrdg_pkg::DIAG_HI_BIT];
      diag0_q    <= addr_q[cbrdg_pkg::DIAG_LO_BIT];
    end
  end

  // Capture enable sampled at the rise, bus latched at the following fall
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sampled_q      <= 1'b0;
      word_q         <= cbrdg_pkg::BLOCK_START;
      words_left_q   <= cbrdg_pkg::NO_WORDS;
      o_rdata        <= 32'h0000_0000;
      o_rdata_valid  <= 1'b0;
      o_core_release <= 1'b0;
      o_read_done    <= 1'b0;
    end else begin
      o_rdata_valid  <= 1'b0;
      o_core_release <= 1'b0;
      o_read_done    <= 1'b0;
      if (start) begin
        word_q       <= cbrdg_pkg::BLOCK_START;
        words_left_q <= s_burst ? cbrdg_pkg::BLOCK_WORDS : cbrdg_pkg::SINGLE_WORDS;
      end
      if ((state_q == cbrdg_pkg::ST_DATA) && (ph_q == cbrdg_pkg::PH_RISE)) begin
        sampled_q      <= !bus.read_capture_enable_n;
        o_core_release <= !bus.ack_n;
      end
      if ((state_q == cbrdg_pkg::ST_DATA) && (ph_q == cbrdg_pkg::PH_FALL) && sampled_q) begin
        sampled_q     <= 1'b0;
        o_rdata       <= bus.ad_bus;
        o_rdata_valid <= 1'b1;
        word_q        <= word_q + 2'h1;
        words_left_q  <= words_left_q - 3'h1;
        o_read_done   <= last_capture;
      end
    end
  end

  assign o_dma_granted             = !grant_n_q;
  assign bus.system_clock_output   = system_clock_output_q;
  assign bus.cpu_ad_o              = ad_o_q;
  assign bus.cpu_ad_oe             = ad_oe_q;
  assign bus.ctl_oe                = ctl_oe_q;
  assign bus.ale                   = ale_q;
  assign bus.rd_n                  = rd_n_q;
  assign bus.burst_n               = burst_n_q;
  assign bus.low_addr              = low_addr_q;
  assign bus.diag1                 = diag1_q;
  assign bus.diag0                 = diag0_q;
  assign bus.memory_drive_permit_n = permit_n_q;
  assign bus.dma_bus_grant_n       = grant_n_q;
endmodule
`default_nettype wire

// ==== cbrdg_mem_end.sv ====
`default_nettype none
module cbrdg_mem_end (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  output logic [31:0]      o_addr,
  output logic             o_addr_valid,
  output logic             o_block,
  input  wire logic        i_dma_want,
  input  wire logic        i_dma_drive,
  input  wire logic [31:0] i_dma_data,
  output logic             o_dma_granted,
  cbrdg_bus_if.mem         bus
);
  logic        sc_prev_q;
  logic        ale_prev_q;
  logic        rise;
  logic        fall;
  logic        f_valid;
  logic        f_pop;
  logic [31:0] f_data;
  logic [2:0]  words_left_q;
  logic        first_q;
  logic        pres_q;
  logic        seen_q;
  logic [31:0] ad_o_q;
  logic        req_n_q;
  logic        dma_drive_q;
  logic [31:0] dma_data_q;

  assign rise  = bus.system_clock_output & ~sc_prev_q;
  assign fall  = ~bus.system_clock_output & sc_prev_q;
  assign f_pop = fall & seen_q;

  cbrdg_fifo #(
    .WIDTH (cbrdg_pkg::AD_W),
    .DEPTH (cbrdg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_wvalid),
    .o_in_ready  (o_wready),
    .i_in_data   (i_wdata),
    .o_out_valid (f_valid),
    .i_out_ready (f_pop),
    .o_out_data  (f_data)
  );

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sc_prev_q  <= 1'b1;
      ale_prev_q <= 1'b0;
    end else begin
      sc_prev_q  <= bus.system_clock_output;
      ale_prev_q <= bus.ale_bus;
    end
  end

  // Address latched as the strobe falls, while the processor still drives the bus
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr       <= 32'h0000_0000;
      o_addr_valid <= 1'b0;
      o_block      <= 1'b0;
    end else begin
      o_addr_valid <= 1'b0;
      if (ale_prev_q && !bus.ale_bus && !bus.rd_bus_n) begin
        o_addr       <= {bus.ad_bus[31:4], bus.low_addr, 2'h0};
        o_addr_valid <= 1'b1;
        o_block      <= !bus.burst_bus_n;
      end
    end
  end

  // One word per two bus cycles: presented at a rise, held over the sampling rise
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      words_left_q <= cbrdg_pkg::NO_WORDS;
      first_q      <= 1'b0;
      pres_q       <= 1'b0;
      seen_q       <= 1'b0;
      ad_o_q       <= 32'h0000_0000;
    end else begin
      if (ale_prev_q && !bus.ale_bus && !bus.rd_bus_n) begin
        words_left_q <= bus.burst_bus_n ? cbrdg_pkg::SINGLE_WORDS : cbrdg_pkg::BLOCK_WORDS;
        first_q      <= 1'b1;
      end else if (f_pop) begin
        words_left_q <= words_left_q - 3'h1;
        first_q      <= 1'b0;
        pres_q       <= 1'b0;
        seen_q       <= 1'b0;
      end else if (rise && pres_q) begin
        seen_q <= 1'b1;
      end else if (rise && f_valid && !bus.permit_bus_n &&
                   (words_left_q != cbrdg_pkg::NO_WORDS)) begin
        pres_q <= 1'b1;
        ad_o_q <= f_data;
      end
    end
  end

  // Request held until the master lets go; raised only between reads
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      req_n_q     <= 1'b1;
      dma_drive_q <= 1'b0;
      dma_data_q  <= 32'h0000_0000;
    end else begin
      req_n_q     <= !(i_dma_want && (!req_n_q ||
                       (bus.rd_bus_n && (words_left_q == cbrdg_pkg::NO_WORDS))));
      dma_drive_q <= i_dma_drive && i_dma_want && !req_n_q && !bus.dma_bus_grant_n;
      dma_data_q  <= i_dma_data;
    end
  end

  assign o_dma_granted             = !req_n_q && !bus.dma_bus_grant_n;
  assign bus.mem_ad_oe             = !bus.permit_bus_n || dma_drive_q;
  assign bus.mem_ad_o              = dma_drive_q ? dma_data_q : ad_o_q;
  assign bus.read_capture_enable_n = !pres_q;
  assign bus.ack_n                 = !(pres_q && first_q);
  assign bus.dma_bus_request_n     = req_n_q;
endmodule
`default_nettype wire

// ==== cbrdg_props.sv ====
`default_nettype none
module cbrdg_props (
  input wire logic       i_clock,
  input wire logic       i_nrst,
  input wire logic       cpu_ad_oe,
  input wire logic       mem_ad_oe,
  input wire logic       ctl_oe,
  input wire logic       ale,
  input wire logic       rd_n,
  input wire logic       burst_n,
  input wire logic [1:0] low_addr,
  input wire logic       diag1,
  input wire logic       diag0,
  input wire logic       memory_drive_permit_n,
  input wire logic       dma_bus_request_n,
  input wire logic       dma_bus_grant_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  chk_addr_with_read: assert property (
    ale |-> !rd_n && cpu_ad_oe && ctl_oe) else $error("latch strobe outside driven read");
  chk_permit_in_addr: assert property (
    ale |-> memory_drive_permit_n) else $error("drive permit low in address phase");
  chk_addr_half_cycle: assert property (
    $rose(ale) |-> ale[*3] ##1 !ale) else $error("address phase not one half cycle");
  chk_turn_order: assert property (
    $fell(ale) |-> cpu_ad_oe && memory_drive_permit_n
      ##1 !cpu_ad_oe && memory_drive_permit_n ##1 !memory_drive_permit_n)
    else $error("turnaround order broken");
  chk_permit_idle: assert property (
    rd_n |-> memory_drive_permit_n) else $error("drive permit low outside a read");
  chk_no_bus_fight: assert property (
    !(cpu_ad_oe && mem_ad_oe)) else $error("both ends drive the bus");
  chk_block_start: assert property (
    $rose(ale) && !burst_n |-> low_addr == 2'h0) else $error("block read not at word 0");
  chk_block_count: assert property (
    !burst_n && !rd_n && $past(!rd_n) && $changed(low_addr)
      |-> low_addr == $past(low_addr) + 2'h1) else $error("block word counter skipped");
  chk_diag_word: assert property (
    $fell(ale) && burst_n |-> {diag1, diag0} == low_addr)
    else $error("diagnostic pins not showing word address");
  chk_grant_bus_free: assert property (
    !dma_bus_grant_n |-> !ctl_oe && !cpu_ad_oe) else $error("grant while still driving");
  chk_grant_soon: assert property (
    $fell(dma_bus_request_n) |-> ##[1:200] !dma_bus_grant_n) else $error("grant too late");
  chk_grant_first: assert property (
    $rose(ctl_oe) |-> dma_bus_grant_n && $past(dma_bus_grant_n))
    else $error("outputs driven before grant dropped");
  chk_bus_return: assert property (
    $rose(dma_bus_request_n) && !dma_bus_grant_n |-> ##[1:4] ctl_oe)
    else $error("bus not returned after request dropped");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        block;
    logic        miss;
    logic        instr;
    logic [3:0]  be;
    logic [31:0] addr;
  } cbrdg_note_t;
  // Case table: instr miss, data miss, uncached, subword data, subword instr
  localparam logic [0:4] MISS_T  = 5'b11011;
  localparam logic [0:4] INSTR_T = 5'b10001;
  localparam logic [3:0] BE_T [5] = '{4'hF, 4'hF, 4'hF, 4'h3, 4'h1};

  logic        i_clock = 1'b0;
  logic        i_nrst = 1'b0;
  logic        strap = 1'b1;
  logic        req_valid = 1'b0, req_miss = 1'b0, req_instr = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic [3:0]  req_be = 4'hF;
  logic        req_ready, rdata_valid, core_release, read_done, cpu_granted;
  logic [31:0] rdata, m_addr;
  logic        wvalid = 1'b0, wready, m_addr_valid, m_block, mem_granted;
  logic [31:0] wdata = 32'h0, dma_data = 32'h0;
  logic        dma_want = 1'b0, dma_drive = 1'b0;
  logic        ale_prev = 1'b0;
  logic [31:0] lfsr_q = 32'h231A;
  logic [31:0] data_q[$];
  cbrdg_note_t note_q[$], mnote_q[$];
  int          pend = 0, miscompares = 0, samples_checked = 0;
  int          cur_left = 0, cur_tot = 0;

  always #4 i_clock = ~i_clock;

  cbrdg_bus_if bus ();
  cbrdg_cpu_end u_cbrdg_cpu_end (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_dcache_block_strap(strap), .i_req_valid(req_valid), .o_req_ready(req_ready),
    .i_req_addr(req_addr), .i_req_miss(req_miss), .i_req_instr(req_instr),
    .i_req_be(req_be), .o_rdata(rdata), .o_rdata_valid(rdata_valid),
    .o_core_release(core_release), .o_read_done(read_done),
    .o_dma_granted(cpu_granted), .bus(bus));
  cbrdg_mem_end u_cbrdg_mem_end (.i_clock(i_clock), .i_nrst(i_nrst), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .o_addr(m_addr), .o_addr_valid(m_addr_valid),
    .o_block(m_block), .i_dma_want(dma_want), .i_dma_drive(dma_drive),
    .i_dma_data(dma_data), .o_dma_granted(mem_granted), .bus(bus));
  cbrdg_props u_cbrdg_props (.i_clock(i_clock), .i_nrst(i_nrst), .cpu_ad_oe(bus.cpu_ad_oe),
    .mem_ad_oe(bus.mem_ad_oe), .ctl_oe(bus.ctl_oe), .ale(bus.ale), .rd_n(bus.rd_n),
    .burst_n(bus.burst_n), .low_addr(bus.low_addr), .diag1(bus.diag1), .diag0(bus.diag0),
    .memory_drive_permit_n(bus.memory_drive_permit_n),
    .dma_bus_request_n(bus.dma_bus_request_n), .dma_bus_grant_n(bus.dma_bus_grant_n));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Entered just after a rising edge; the word only counts once ready is seen
  task automatic push_words(input int n);
    int w;
    for (int k = 0; k < n; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wvalid = 1'b1;
      wdata = lfsr_q;
      w = 0;
      do begin
        @(negedge i_clock);
        w++;
      end while (wready !== 1'b1 && w < 50);
      data_q.push_back(lfsr_q);
      @(posedge i_clock);
      #1;
    end
    wvalid = 1'b0;
  endtask

  task automatic read_req(input logic [31:0] a, input logic m, input logic ins,
                          input logic [3:0] be);
    cbrdg_note_t n;
    int          w;
    n.block = m && (ins || strap) && (be == 4'hF);
    n.miss = m;
    n.instr = ins;
    n.addr = a;
    n.be = be;
    note_q.push_back(n);
    mnote_q.push_back(n);
    pend += n.block ? 4 : 1;
    req_valid = 1'b1;
    req_addr = a;
    req_miss = m;
    req_instr = ins;
    req_be = be;
    w = 0;
    do begin
      @(negedge i_clock);
      w++;
    end while (req_ready !== 1'b1 && w < 400);
    @(posedge i_clock);
    #1;
    req_valid = 1'b0;
    // One edge with the strobe low before the next request
    @(posedge i_clock);
    #1;
  endtask

  task automatic run_table();
    for (int i = 0; i < 5; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      read_req(lfsr_q, MISS_T[i], INSTR_T[i], BE_T[i]);
    end
  endtask

  task automatic wait_idle();
    int w;
    w = 0;
    while (pend != 0 && w < 3000) begin
      @(negedge i_clock);
      w++;
    end
    check("words_outstanding", 32'h0, 32'(pend));
    @(posedge i_clock);
    #1;
  endtask

  // Results are matched in order against the notes left by the drivers
  always @(negedge i_clock) begin
    cbrdg_note_t n;
    if (i_nrst === 1'b1) begin
      if (rdata_valid === 1'b1) begin
        check("o_rdata", (data_q.size() != 0) ? data_q.pop_front() : ~rdata, rdata);
        pend--;
        cur_left--;
        check("o_read_done", {31'h0, cur_left == 0}, {31'h0, read_done});
      end
      if (core_release === 1'b1) begin
        check("o_core_release", 32'(cur_tot), 32'(cur_left));
      end
      if (bus.ale_bus === 1'b1 && ale_prev !== 1'b1) begin
        n = (note_q.size() != 0) ? note_q.pop_front() : '0;
        cur_tot = n.block ? 4 : 1;
        cur_left = cur_tot;
        check("ad_be", {28'h0, ~n.be}, {28'h0, bus.ad_bus[3:0]});
        check("burst_n", {31'h0, ~n.block}, {31'h0, bus.burst_bus_n});
        check("rd_n", 32'h0, {31'h0, bus.rd_bus_n});
        check("ad_addr", {4'h0, n.addr[31:4]}, {4'h0, bus.ad_bus[31:4]});
        check("diag1", {31'h0, n.miss}, {31'h0, bus.diag1});
        if (n.miss) begin
          check("diag0", {31'h0, n.instr}, {31'h0, bus.diag0});
        end
        check("low_addr", {30'h0, n.block ? 2'h0 : n.addr[3:2]}, {30'h0, bus.low_addr});
      end
      if (m_addr_valid === 1'b1) begin
        n = (mnote_q.size() != 0) ? mnote_q.pop_front() : '0;
        check("o_block", {31'h0, n.block}, {31'h0, m_block});
        check("o_addr", {n.addr[31:4], n.block ? 2'h0 : n.addr[3:2], 2'h0}, m_addr);
        check("diag_addr", {30'h0, n.addr[3:2]}, {30'h0, bus.diag1, bus.diag0});
      end
    end
    ale_prev = bus.ale_bus;
  end

  initial begin
    repeat (40000) @(posedge i_clock);
    miscompares++;
    give_verdict();
  end

  initial begin
    int   w;
    logic taken;
    repeat (6) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    push_words(16);
    @(posedge i_clock);
    #1;
    wvalid = 1'b1;
    @(negedge i_clock);
    check("wready_full", 32'h0, {31'h0, wready});
    @(posedge i_clock);
    #1;
    wvalid = 1'b0;
    run_table();
    wait_idle();
    // Second reset with words left behind, data misses now single
    strap = 1'b0;
    i_nrst = 1'b0;
    repeat (6) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    data_q.delete();
    note_q.delete();
    mnote_q.delete();
    pend = 0;
    push_words(8);
    run_table();
    wait_idle();
    // Buffer empty: the read must stall until a word arrives
    read_req(32'h0000_2004, 1'b0, 1'b0, 4'hF);
    repeat (40) @(negedge i_clock);
    check("stalled_words", 32'h1, 32'(pend));
    @(posedge i_clock);
    #1;
    push_words(2);
    wait_idle();
    dma_want = 1'b1;
    w = 0;
    do begin
      @(negedge i_clock);
      w++;
    end while (cpu_granted !== 1'b1 && w < 200);
    check("ctl_oe_in_dma", 32'h0, {31'h0, bus.ctl_oe});
    @(posedge i_clock);
    #1;
    dma_drive = 1'b1;
    dma_data = lfsr_next(lfsr_q);
    req_valid = 1'b1;
    taken = 1'b0;
    repeat (30) begin
      @(negedge i_clock);
      if (req_ready === 1'b1) taken = 1'b1;
    end
    check("taken_in_dma", 32'h0, {31'h0, taken});
    check("dma_ad", dma_data, bus.ad_bus);
    check("mem_granted", 32'h1, {31'h0, mem_granted});
    @(posedge i_clock);
    #1;
    dma_drive = 1'b0;
    @(posedge i_clock);
    #1;
    dma_want = 1'b0;
    read_req(32'h0000_1008, 1'b0, 1'b0, 4'hF);
    wait_idle();
    give_verdict();
  end
endmodule
`default_nettype wire
